/* rtl/rsi_reset_init.sv */
// reset state initializer: reset sequencing, reset-value register image and pin control
`default_nettype none
`include "rsi_map.svh"
// Contract
// - any reset drives indicator port bit low
// - watchdog reset also resets the watchdog
// - program counter undefined during reset and stall
// - standby reset keeps RAM and registers
// - port latches cleared, port 2 latch kept
// - port direction registers load all ones
// - pull-up option registers cleared
// - memory size switch loads CFH
// - expansion RAM size switch loads 0CH
// - clock control and stabilization status cleared
// - wide timer counters and compares cleared
// - wide timer control registers cleared
// - narrow timer registers cleared
// - interval timer and carrier registers cleared
// - watch timer mode cleared, timer stopped
// - clock output select register cleared
// - execution restarts from vector at 0000H
// - cpu clock stalls 17 oscillator periods
// - pins high impedance except indicator low
module rsi_reset_init
  import rsi_pkg::*;
(
  input  wire logic                         SYS_CLK,
  input  wire logic                         RST,
  input  wire logic                         EXT_RESET_N,
  input  wire logic                         WDT_OVERFLOW,
  input  wire logic                         CLK_MON_STOP,
  input  wire logic                         POC_DETECT,
  input  wire logic                         LVI_DETECT,
  input  wire logic                         STANDBY,
  input  wire rsi_cfg_req_t                 CFG,
  input  wire rsi_gpr_req_t                 GPR,
  output logic                              CPU_RESET,
  output logic                              PC_VALID,
  output logic                              PC_LOAD,
  output logic [15:0]                       PC_VECTOR,
  output logic                              WDT_RESTART,
  output logic                              MEM_RETAINED,
  output logic [7:0]                        CFG_RDATA,
  output logic [7:0]                        GPR_RDATA,
  output logic [`RSI_NREG*8-1:0]            REG_IMAGE,
  output logic [`RSI_NPORT*8-1:0]           PORT_OUT,
  output logic [`RSI_NPORT*8-1:0]           PORT_OE
);
  localparam int IND_POS = `RSI_IND_PORT * 8 + `RSI_IND_BIT;

  rsi_state_t                state;
  rsi_state_t                next_state;
  logic                      any_src;
  logic                      load_reset;
  logic                      cfg_open;
  logic                      gpr_we;
  logic                      stall_busy;
  logic                      stall_done;
  logic                      in_reset_next;
  logic [`RSI_NREG*8-1:0]    next_regs;
  logic [`RSI_NPORT*8-1:0]   latch_out;
  logic [`RSI_NPORT*8-1:0]   latch_oe;

  // internal sources are pulses, the external pin is a level; all merge here
  assign any_src = ~EXT_RESET_N | WDT_OVERFLOW | CLK_MON_STOP | POC_DETECT | LVI_DETECT;

  // reset values are forced for as long as a source stands, from its first cycle
  assign load_reset = any_src | RST;

  // software writes land only in normal execution
  assign cfg_open = (state.phase == RSI_RUN) & ~any_src;

  assign gpr_we = GPR.we & cfg_open;

  genvar gi;
  generate
    for (gi = 0; gi < `RSI_NREG; gi++)
    begin : g_reg
      localparam logic [7:0] RV   = rsi_reset_value(gi);
      localparam bit         KEEP = (gi == `RSI_PORT_BASE + `RSI_HELD_LATCH);
      logic [7:0] cur;
      logic       hit;
      assign cur = state.regs[gi*8 +: 8];
      assign hit = CFG.we & cfg_open & (int'(CFG.idx) == gi);
      // port 2 latch is left as it was; undefined after reset anyway
      assign next_regs[gi*8 +: 8] = load_reset ? (KEEP ? cur : RV)
                                  : (hit ? CFG.wdata : cur);
    end
  endgenerate

  generate
    for (gi = 0; gi < `RSI_NPORT; gi++)
    begin : g_port
      assign latch_out[gi*8 +: 8] = next_regs[(`RSI_PORT_BASE + gi)*8 +: 8];
      assign latch_oe[gi*8 +: 8]  = ~next_regs[(`RSI_DIR_BASE + gi)*8 +: 8];
    end
  endgenerate

  rsi_stall_timer u_stall
  (
    .clk   (SYS_CLK),
    .rst   (RST),
    .start (state.stall_start),
    .abort (state.phase == RSI_HELD),
    .busy  (stall_busy),
    .done  (stall_done)
  );

  rsi_gpr_mem u_gpr
  (
    .clk   (SYS_CLK),
    .rst   (RST),
    .we    (gpr_we),
    .addr  (GPR.addr),
    .wdata (GPR.wdata),
    .rdata (GPR_RDATA)
  );

  always_comb
  begin
    next_state             = state;
    next_state.pc_load     = 1'b0;
    next_state.stall_start = 1'b0;
    next_state.regs        = next_regs;
    case (state.phase)
      RSI_RUN:
      begin
        if (any_src)
        begin
          next_state.phase        = RSI_HELD;
          next_state.standby_seen = STANDBY;
        end
      end
      RSI_HELD:
      begin
        if (!any_src)
        begin
          next_state.phase       = RSI_STALL;
          next_state.stall_start = 1'b1;
        end
      end
      RSI_STALL:
      begin
        // a new source during the stall restarts the whole sequence
        if (any_src)
        begin
          next_state.phase        = RSI_HELD;
          next_state.standby_seen = STANDBY;
        end
        else if (stall_done && !state.stall_start)
          next_state.phase = RSI_VECTOR;
      end
      RSI_VECTOR:
      begin
        if (any_src)
        begin
          next_state.phase        = RSI_HELD;
          next_state.standby_seen = STANDBY;
        end
        else
        begin
          next_state.phase   = RSI_RUN;
          next_state.pc_load = 1'b1;
        end
      end
      default:
      begin
        next_state.phase = RSI_HELD;
      end
    endcase

    in_reset_next = (next_state.phase == RSI_HELD) || (next_state.phase == RSI_STALL);
    next_state.cpu_reset   = in_reset_next;
    next_state.pc_valid    = (next_state.phase == RSI_RUN);
    next_state.vector_addr = `RSI_VECTOR_ADDR;
    // every source restarts the watchdog, its own overflow included
    next_state.wdt_restart = (next_state.phase == RSI_HELD);

    // rsi keeps pins released until the stall ends, not only while a source stands
    if (in_reset_next)
    begin
      next_state.port_out = '0;
      next_state.port_oe  = '0;
    end
    else
    begin
      next_state.port_out = latch_out;
      next_state.port_oe  = latch_oe;
    end
    // the indicator bit is output only: low in reset, its latch otherwise
    next_state.port_out[IND_POS] = in_reset_next ? 1'b0 : latch_out[IND_POS];
    next_state.port_oe[IND_POS]  = 1'b1;

    next_state.rdata = `RSI_RV_ZERO;
    if (int'(CFG.idx) < `RSI_NREG)
      next_state.rdata = state.regs[int'(CFG.idx)*8 +: 8];
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      state              <= '0;
      state.phase        <= RSI_HELD;
      state.regs         <= rsi_reset_image();
      state.cpu_reset    <= 1'b1;
      state.wdt_restart  <= 1'b1;
      state.vector_addr  <= `RSI_VECTOR_ADDR;
      state.port_oe      <= '0;
      state.port_oe[IND_POS] <= 1'b1;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign CPU_RESET    = state.cpu_reset;
  assign PC_VALID     = state.pc_valid;
  assign PC_LOAD      = state.pc_load;
  assign PC_VECTOR    = state.vector_addr;
  assign WDT_RESTART  = state.wdt_restart;
  assign MEM_RETAINED = state.standby_seen;
  assign CFG_RDATA    = state.rdata;
  assign REG_IMAGE    = state.regs;
  assign PORT_OUT     = state.port_out;
  assign PORT_OE      = state.port_oe;
endmodule
`default_nettype wire

/* rtl/rsi_map.svh */
// register map, reset values and timing counts of the reset state initializer
`ifndef RSI_MAP_SVH
`define RSI_MAP_SVH
`define RSI_NPORT        8
`define RSI_PORT_BASE    0
`define RSI_DIR_BASE     8
`define RSI_PU_BASE      16
`define RSI_ISC          24
`define RSI_IMS          25
`define RSI_IXS          26
`define RSI_PCC          27
`define RSI_RCM          28
`define RSI_MCM          29
`define RSI_MOC          30
`define RSI_STABILIZATION_TIME_SELECT         31
`define RSI_STABILIZATION_COUNTER_STATUS         32
`define RSI_PSW          33
`define RSI_WT_CNT_BASE  34
`define RSI_WT_CR_BASE   38
`define RSI_WT_CTL_BASE  46
`define RSI_NT_BASE      54
`define RSI_IT_BASE      62
`define RSI_CARRIER      68
`define RSI_WATCH        69
`define RSI_CLKOUT       70
`define RSI_WDT_MODE     71
`define RSI_WDT_EN       72
`define RSI_NREG         73
`define RSI_IDX_W        7
`define RSI_HELD_LATCH   2
`define RSI_IND_PORT     7
`define RSI_IND_BIT      0
`define RSI_RV_ZERO      8'h00
`define RSI_RV_DIR       8'hff
`define RSI_RV_IMS       8'hcf
`define RSI_RV_IXS       8'h0c
`define RSI_RV_PSW       8'h02
`define RSI_RV_STABILIZATION_TIME_SELECT      8'h05
`define RSI_RV_WDT_MODE  8'h67
`define RSI_RV_WDT_EN    8'h9a
`define RSI_VECTOR_ADDR  16'h0000
`define RSI_GPR_DEPTH    32
`define RSI_GPR_AW       5
`define RSI_CLK_HZ       10000000
`define RSI_FR_HZ        10000000
`define RSI_FR_PERIODS   17
`define RSI_STALL_CYCLES ((`RSI_FR_PERIODS * `RSI_CLK_HZ + `RSI_FR_HZ - 1) / `RSI_FR_HZ)
`define RSI_STALL_W      8
`endif

/* rtl/rsi_pkg.sv */
// types and reset value functions of the reset state initializer
`default_nettype none
`include "rsi_map.svh"
package rsi_pkg;
  typedef enum logic [1:0] {RSI_RUN, RSI_HELD, RSI_STALL, RSI_VECTOR} rsi_phase_t;
  typedef struct packed {
    logic                  we;
    logic [`RSI_IDX_W-1:0] idx;
    logic [7:0]            wdata;
  } rsi_cfg_req_t;
  typedef struct packed {
    logic                   we;
    logic [`RSI_GPR_AW-1:0] addr;
    logic [7:0]             wdata;
  } rsi_gpr_req_t;
  typedef struct packed {
    rsi_phase_t                phase;
    logic [`RSI_NREG*8-1:0]    regs;
    logic [7:0]                rdata;
    logic                      cpu_reset;
    logic                      pc_valid;
    logic                      pc_load;
    logic [15:0]               vector_addr;
    logic                      wdt_restart;
    logic                      standby_seen;
    logic                      stall_start;
    logic [`RSI_NPORT*8-1:0]   port_out;
    logic [`RSI_NPORT*8-1:0]   port_oe;
  } rsi_state_t;
  typedef struct packed {
    logic [`RSI_STALL_W-1:0] count;
    logic                    busy;
    logic                    done;
  } rsi_timer_state_t;
  typedef struct packed {
    logic [`RSI_GPR_DEPTH-1:0][7:0] cells;
    logic [7:0]                     rdata;
  } rsi_mem_state_t;

  function automatic logic [7:0] rsi_reset_value(input int i);
    logic [7:0] rv;
    rv = `RSI_RV_ZERO;
    if (i >= `RSI_DIR_BASE && i < `RSI_DIR_BASE + `RSI_NPORT)
    begin
      rv = `RSI_RV_DIR;
    end
    else
    begin
      case (i)
        `RSI_IMS:      rv = `RSI_RV_IMS;
        `RSI_IXS:      rv = `RSI_RV_IXS;
        `RSI_PSW:      rv = `RSI_RV_PSW;
        `RSI_STABILIZATION_TIME_SELECT:     rv = `RSI_RV_STABILIZATION_TIME_SELECT;
        `RSI_WDT_MODE: rv = `RSI_RV_WDT_MODE;
        `RSI_WDT_EN:   rv = `RSI_RV_WDT_EN;
        default:       rv = `RSI_RV_ZERO;
      endcase
    end
    return rv;
  endfunction

  function automatic logic [`RSI_NREG*8-1:0] rsi_reset_image();
    logic [`RSI_NREG*8-1:0] img;
    img = '0;
    for (int i = 0; i < `RSI_NREG; i++)
    begin
      img[i*8 +: 8] = rsi_reset_value(i);
    end
    return img;
  endfunction
endpackage
`default_nettype wire

/* rtl/rsi_stall_timer.sv */
// counter for the cpu clock stall that follows reset release
`default_nettype none
`include "rsi_map.svh"
module rsi_stall_timer
  import rsi_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  input  wire logic abort,
  output logic      busy,
  output logic      done
);
  rsi_timer_state_t state;
  rsi_timer_state_t next_state;

  always_comb
  begin
    next_state      = state;
    next_state.done = 1'b0;
    if (abort)
    begin
      next_state.busy  = 1'b0;
      next_state.count = '0;
    end
    else if (start)
    begin
      next_state.busy  = 1'b1;
      next_state.count = `RSI_STALL_W'(`RSI_STALL_CYCLES - 1);
    end
    else if (state.busy)
    begin
      if (state.count == '0)
      begin
        next_state.busy = 1'b0;
        next_state.done = 1'b1;
      end
      else
      begin
        next_state.count = state.count - `RSI_STALL_W'(1);
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      state <= '0;
    else
      state <= next_state;
  end

  assign busy = state.busy;
  assign done = state.done;
endmodule
`default_nettype wire

/* rtl/rsi_gpr_mem.sv */
// general-purpose register memory, kept across any reset
`default_nettype none
`include "rsi_map.svh"
module rsi_gpr_mem
  import rsi_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   we,
  input  wire logic [`RSI_GPR_AW-1:0] addr,
  input  wire logic [7:0]             wdata,
  output logic [7:0]                  rdata
);
  rsi_mem_state_t state;
  rsi_mem_state_t next_state;

  always_comb
  begin
    next_state       = state;
    next_state.rdata = state.cells[addr];
    if (we)
      next_state.cells[addr] = wdata;
  end

  // cells are never cleared, so standby contents survive a reset
  always_ff @(posedge clk)
  begin
    if (rst)
      state.rdata <= '0;
    else
      state.rdata <= next_state.rdata;
    state.cells <= next_state.cells;
  end

  assign rdata = state.rdata;
endmodule
`default_nettype wire

/* bench/rsi_src_model.sv */
// reset source model: asserts one of the five reset requests on command
`default_nettype none
module rsi_src_model
(
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [2:0] sel,
  input  wire logic [7:0] len,
  output logic [4:0]      req
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt = 8'h00;
  logic [2:0] cur = 3'h0;
  // the pin source is stretched to the minimum low time whatever the bench asks
  always @(posedge clk)
  begin
    if (go)
    begin
      cur <= sel;
      cnt <= (sel == 3'h0 && len < 8'h64) ? 8'h64 : len;
    end
    else if (cnt != 8'h00)
      cnt <= cnt - 8'h01;
  end
  // bit 0 is the pin request, inverted by the bench into the active-low pin
  always_comb req = (cnt != 8'h00) ? (5'h01 << cur) : 5'h00;
endmodule
`default_nettype wire

/* bench/rsi_reset_init_chk.sv */
// port assertions of the reset state initializer
`default_nettype none
module rsi_reset_init_chk
(
  input wire logic         SYS_CLK,
  input wire logic         RST,
  input wire logic         EXT_RESET_N,
  input wire logic         WDT_OVERFLOW,
  input wire logic         CLK_MON_STOP,
  input wire logic         POC_DETECT,
  input wire logic         LVI_DETECT,
  input wire logic         STANDBY,
  input wire logic         CPU_RESET,
  input wire logic         PC_VALID,
  input wire logic         PC_LOAD,
  input wire logic [15:0]  PC_VECTOR,
  input wire logic         WDT_RESTART,
  input wire logic         MEM_RETAINED,
  input wire logic [583:0] REG_IMAGE,
  input wire logic [63:0]  PORT_OUT,
  input wire logic [63:0]  PORT_OE
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic src = !EXT_RESET_N || WDT_OVERFLOW || CLK_MON_STOP || POC_DETECT || LVI_DETECT;
  logic [7:0] held;
  // counts held cycles since the last source fell; saturates so it never wraps
  always_ff @(posedge SYS_CLK)
    held <= (src || RST) ? 8'h00 : (CPU_RESET && held != 8'hff) ? held + 8'h01 : held;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  sequence released_s;
    src ##1 !src;
  endsequence
  ind_low_a: assert property (src |=> !PORT_OUT[56])
    else $error("indicator not low in reset");
  pins_off_a: assert property (src |=> PORT_OE == 64'h0100000000000000)
    else $error("pins driven in reset");
  wdt_self_a: assert property (WDT_OVERFLOW |=> WDT_RESTART && REG_IMAGE[568 +: 16] == 16'h9a67)
    else $error("watchdog not reset");
  pc_undef_a: assert property (CPU_RESET |-> !PC_VALID)
    else $error("pc valid in reset");
  vector_a: assert property (PC_LOAD |-> PC_VECTOR == 16'h0000 && PC_VALID && !CPU_RESET)
    else $error("bad start vector");
  stall_len_a: assert property (PC_LOAD |-> held >= 8'h11 && held <= 8'h18)
    else $error("stall too short or long");
  stall_end_a: assert property (released_s |-> (##[1:24] src) or (##[17:24] PC_LOAD))
    else $error("no restart after stall");
  set_vals_a: assert property (src |=> REG_IMAGE[64 +: 8] == 8'hff
    && REG_IMAGE[200 +: 16] == 16'h0ccf) else $error("set values not loaded");
  clear_vals_a: assert property (src |=> REG_IMAGE[7:0] == 8'h00
    && REG_IMAGE[135:128] == 8'h00 && REG_IMAGE[216 +: 32] == '0 && REG_IMAGE[256 +: 8] == 8'h00
    && REG_IMAGE[272 +: 8] == 8'h00 && REG_IMAGE[304 +: 16] == '0
    && REG_IMAGE[368 +: 8] == 8'h00 && REG_IMAGE[432 +: 8] == 8'h00
    && REG_IMAGE[496 +: 8] == 8'h00 && REG_IMAGE[544 +: 24] == '0)
    else $error("cleared values not loaded");
  retain_a: assert property ($rose(src) |=> MEM_RETAINED == $past(STANDBY))
    else $error("standby not captured");
endmodule
bind rsi_reset_init rsi_reset_init_chk rsi_reset_init_chk_inst (.SYS_CLK(SYS_CLK), .RST(RST),
  .EXT_RESET_N(EXT_RESET_N), .WDT_OVERFLOW(WDT_OVERFLOW), .CLK_MON_STOP(CLK_MON_STOP),
  .POC_DETECT(POC_DETECT), .LVI_DETECT(LVI_DETECT), .STANDBY(STANDBY), .CPU_RESET(CPU_RESET),
  .PC_VALID(PC_VALID), .PC_LOAD(PC_LOAD), .PC_VECTOR(PC_VECTOR), .WDT_RESTART(WDT_RESTART),
  .MEM_RETAINED(MEM_RETAINED), .REG_IMAGE(REG_IMAGE), .PORT_OUT(PORT_OUT), .PORT_OE(PORT_OE));
`default_nettype wire

/* bench/tb_rsi_reset_init.sv */
// self-checking bench of the reset state initializer
`default_nettype none
module tb_rsi_reset_init
  import rsi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic         sys_clk = 1'b0, rst = 1'b1, standby = 1'b0, go = 1'b0;
  logic [2:0]   sel = 3'h0;
  logic [7:0]   len = 8'h04;
  logic [4:0]   req;
  rsi_cfg_req_t cfg = '0;
  rsi_gpr_req_t gpr = '0;
  logic         cpu_reset, pc_valid, pc_load, wdt_restart, mem_retained;
  logic [15:0]  pc_vector;
  logic [7:0]   gpr_rdata, cfg_rdata;
  logic [583:0] reg_image;
  logic [63:0]  port_out, port_oe;
  int           failures = 0, n_checks = 0, cyc = 0;
  // rows: index, written byte, byte expected after a source reset
  logic [23:0]  rows [20] = '{24'h005a00, 24'h025a5a, 24'h0812ff, 24'h0f34ff, 24'h105a00,
    24'h1900cf, 24'h1a000c, 24'h1b5a00, 24'h1c5a00, 24'h1d5a00, 24'h1e5a00, 24'h205a00,
    24'h225a00, 24'h295a00, 24'h2e5a00, 24'h365a00, 24'h3e5a00, 24'h445a00, 24'h455a00,
    24'h465a00};

  rsi_reset_init rsi_reset_init_inst (.SYS_CLK(sys_clk), .RST(rst), .EXT_RESET_N(~req[0]),
    .WDT_OVERFLOW(req[1]), .CLK_MON_STOP(req[2]), .POC_DETECT(req[3]), .LVI_DETECT(req[4]),
    .STANDBY(standby), .CFG(cfg), .GPR(gpr), .CPU_RESET(cpu_reset), .PC_VALID(pc_valid),
    .PC_LOAD(pc_load), .PC_VECTOR(pc_vector), .WDT_RESTART(wdt_restart),
    .MEM_RETAINED(mem_retained), .CFG_RDATA(cfg_rdata), .GPR_RDATA(gpr_rdata),
    .REG_IMAGE(reg_image), .PORT_OUT(port_out), .PORT_OE(port_oe));
  rsi_src_model rsi_src_model_inst (.clk(sys_clk), .go(go), .sel(sel), .len(len), .req(req));

  initial
  begin
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // a hang is cut short at 8000 cycles, well above the thousand or so cycles the run needs
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      failures++;
      summarize();
    end
  end
  task automatic tick(input int n = 1);
    repeat (n) @(posedge sys_clk);
    #10;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_f(input string what, input logic exp, input logic got);
    chk(what, {7'h00, exp}, {7'h00, got});
  endtask
  function automatic logic [7:0] byte_at(input int i);
    return reg_image[i*8 +: 8];
  endfunction
  // caller lowers cfg.we, so back-to-back writes never touch it twice in a step
  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    cfg = '{1'b1, i, d};
    tick();
  endtask
  task automatic hit(input logic [2:0] s, input logic [7:0] n);
    sel = s;
    len = n;
    go = 1'b1;
    tick();
    go = 1'b0;
    tick(2);
    chk_f("indicator", 1'b0, port_out[56]);
    chk("oe_top", 8'h01, port_oe[63:56]);
    chk_f("pc_valid", 1'b0, pc_valid);
    chk_f("cpu_reset", 1'b1, cpu_reset);
    chk_f("wdt_restart", 1'b1, wdt_restart);
  endtask
  task automatic wait_run();
    int k;
    k = 0;
    while (pc_load !== 1'b1 && k < 300)
    begin
      tick();
      k++;
    end
    chk_f("pc_load", 1'b1, pc_load);
    chk("vector", 8'h00, pc_vector[7:0] | pc_vector[15:8]);
    tick();
  endtask

  initial
  begin
    tick(20);
    rst = 1'b0;
    wait_run();
    foreach (rows[r])
    begin
      wr(rows[r][22:16], rows[r][15:8]);
      cfg.we = 1'b0;
      chk("written", rows[r][15:8], byte_at(rows[r][23:16]));
      hit(3'(r % 5), 8'h04);
      wait_run();
      chk("reset_val", rows[r][7:0], byte_at(rows[r][23:16]));
    end
    wr(7'h0f, 8'hfe);
    wr(7'h07, 8'h01);
    cfg.we = 1'b0;
    tick();
    chk_f("indicator_set", 1'b1, port_out[56]);
    chk("cfg_rdata", 8'h01, cfg_rdata);
    hit(3'h1, 8'h04);
    tick(3);
    wr(7'h20, 8'h77);
    cfg.we = 1'b0;
    chk("write_in_stall", 8'h00, byte_at(32));
    hit(3'h3, 8'h02);
    wait_run();
    gpr = '{1'b1, 5'h03, 8'h5a};
    tick();
    gpr.we = 1'b0;
    standby = 1'b1;
    hit(3'h2, 8'h04);
    chk_f("retained", 1'b1, mem_retained);
    chk("gpr_kept", 8'h5a, gpr_rdata);
    wait_run();
    standby = 1'b0;
    hit(3'h0, 8'h04);
    chk_f("retained_off", 1'b0, mem_retained);
    wait_run();
    summarize();
  end
endmodule
`default_nettype wire
